//--- verilog/evt_notify_pkg.sv
// constants and carrier types for the camera event notifier
// assumes a 32-bit apb slave on pclk and same-clock event pulses
package evt_notify_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_EVT = 42;
   localparam int SEL_W   = 6;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 8;
   localparam int SPD_W   = 3;
   localparam int XFER_N  = 11;

   // ==========================================================
   // event source codes, as written to the selector
   localparam int EV_XFER_BASE  = 0;   // 11 stream/block/burst/queue/seq
   localparam int EV_CNT_BASE   = 11;  // begin,done for cnt0 then cnt1
   localparam int EV_TMR_BASE   = 15;  // begin,done for tmr0 then tmr1
   localparam int EV_ENC_HALT   = 19;
   localparam int EV_ENC_RESUME = 21;
   localparam int EV_IN_RISE    = 23;
   localparam int EV_IN_FALL    = 25;
   localparam int EV_IN_TOGGLE  = 27;
   localparam int EV_LT_RISE    = 29;
   localparam int EV_LT_FALL    = 31;
   localparam int EV_LT_TOGGLE  = 33;
   localparam int EV_LATE       = 35;
   localparam int EV_SPEED      = 36;
   localparam int EV_SWITCH     = 37;
   localparam int EV_ERROR      = 38;
   localparam int EV_TEST       = 39;
   localparam int EV_FRAME_TRIG = 40;
   localparam int EV_EXPO_DONE  = 41;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_SELECT  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_TEST    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_ENC_TMO = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_PEND_LO = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PEND_HI = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_FT_ID   = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_FT_TIME = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_FT_FRM  = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_ED_ID   = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_ED_TIME = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_ED_FRM  = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_NOW     = 8'h30;

   // ==========================================================
   // type identifiers (values arbitrary) and reset values
   localparam logic [DATA_W-1:0] ID_FRAME_TRIG = 32'h0000_9000;
   localparam logic [DATA_W-1:0] ID_EXPO_DONE  = 32'h0000_9001;
   localparam logic [DATA_W-1:0] ENC_TMO_RST   = 32'h0000_FFFF;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic [DATA_W-1:0] ts;
      logic [DATA_W-1:0] fid;
   } capture_t;

   typedef struct packed {
      logic [SEL_W-1:0]        sel;
      logic [NUM_EVT-1:0]      en;
      logic [NUM_EVT-1:0]      pend;
      logic [DATA_W-1:0]       tmo;
      logic [DATA_W-1:0]       ts;
      capture_t                ft;
      capture_t                ed;
      logic [3:0]              pin_s1;
      logic [3:0]              pin_s2;
      logic [3:0]              pin_prev;
      logic [1:0]              enc_s1;
      logic [1:0]              enc_s2;
      logic [1:0]              enc_prev;
      logic [1:0][DATA_W-1:0]  enc_idle;
      logic [1:0]              enc_halt;
      logic [1:0]              cnt_prev;
      logic [1:0]              tmr_prev;
      logic [SPD_W-1:0]        spd_prev;
      logic                    test_req;
      logic                    notify;
      logic [SEL_W-1:0]        code;
      logic                    pready;
      logic                    pslverr;
      logic [DATA_W-1:0]       prdata;
   } evt_state_t;

endpackage

//--- verilog/camera_event_notifier.sv
// event detection, per-source reporting enable and event data capture
// assumes apb on pclk; line, link-trigger and encoder pins are async
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - selector picks source; enable access follows it
// - stream transfer begin and done events
// - stream pause and resume events
// - per-block begin and done events
// - block trigger accepted raises event
// - burst begin and done events
// - transfer queue overflow raises event
// - sequencer set change raises event
// - counters 0,1 begin and done events
// - timers 0,1 begin and done events
// - encoder idle beyond timeout raises halt
// - halted encoder moving again raises resume
// - input line rising edge event
// - input line falling edge event
// - input line either edge event
// - link trigger rise, fall, toggle events
// - action scheduled in the past raises event
// - link speed change raises event
// - granted switchover raises event
// - device error raises event
// - test command event, always reported
// - off suppresses, on reports selected event
// - read-only type identifiers for captures
// - capture timestamp and frame identifier
module camera_event_notifier
   import evt_notify_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // same-clock event sources
   input  wire logic [XFER_N-1:0] xfer_evt,
   input  wire logic [1:0]        cnt_run,
   input  wire logic [1:0]        tmr_run,
   input  wire logic              action_valid,
   input  wire logic [DATA_W-1:0] action_time,
   input  wire logic [SPD_W-1:0]  link_speed,
   input  wire logic              switch_grant,
   input  wire logic              dev_error,
   input  wire logic              frame_trig,
   input  wire logic              expo_done,
   input  wire logic [DATA_W-1:0] frame_id,
   // asynchronous pins
   input  wire logic [1:0]        line_in,
   input  wire logic [1:0]        ltrig_in,
   input  wire logic [1:0]        enc_step,
   // notification toward the message transport
   output logic                   notify_valid,
   output logic      [SEL_W-1:0]  notify_code
);

   // =============================================================
   // state
   localparam evt_state_t ST_RST = '{tmo: ENC_TMO_RST, default: '0};
   localparam logic [NUM_EVT-1:0] TEST_MASK = NUM_EVT'(1) << EV_TEST;

   evt_state_t s_reg;
   evt_state_t s_next;

   logic [3:0]         rise_w;
   logic [3:0]         fall_w;
   logic [1:0]         motion_w;
   logic               acc_w;
   logic               commit_w;

   assign rise_w   = s_reg.pin_s2 & ~s_reg.pin_prev;
   assign fall_w   = ~s_reg.pin_s2 & s_reg.pin_prev;
   assign motion_w = s_reg.enc_s2 ^ s_reg.enc_prev;
   assign acc_w    = psel & penable;
   // one wait state: the write lands on the edge that sees pready
   assign commit_w = acc_w & s_reg.pready;

   // =============================================================
   // next-state logic
   always_comb begin
      logic [NUM_EVT-1:0] raise;
      logic [NUM_EVT-1:0] clr;
      logic [SEL_W-1:0]   pick;
      logic               hit;
      raise  = '0;
      clr    = '0;
      pick   = '0;
      hit    = 1'b0;
      s_next = s_reg;

      s_next.ts       = s_reg.ts + 1'b1;
      s_next.pin_s1   = {ltrig_in, line_in};
      s_next.pin_s2   = s_reg.pin_s1;
      s_next.pin_prev = s_reg.pin_s2;
      s_next.enc_s1   = enc_step;
      s_next.enc_s2   = s_reg.enc_s1;
      s_next.enc_prev = s_reg.enc_s2;
      s_next.cnt_prev = cnt_run;
      s_next.tmr_prev = tmr_run;
      s_next.spd_prev = link_speed;
      s_next.test_req = 1'b0;

      raise[EV_XFER_BASE +: XFER_N] = xfer_evt;

      for (int i = 0; i < 2; i++) begin
         raise[EV_CNT_BASE+2*i]   = cnt_run[i] & ~s_reg.cnt_prev[i];
         raise[EV_CNT_BASE+2*i+1] = ~cnt_run[i] & s_reg.cnt_prev[i];
         raise[EV_TMR_BASE+2*i]   = tmr_run[i] & ~s_reg.tmr_prev[i];
         raise[EV_TMR_BASE+2*i+1] = ~tmr_run[i] & s_reg.tmr_prev[i];
         raise[EV_IN_RISE+i]      = rise_w[i];
         raise[EV_IN_FALL+i]      = fall_w[i];
         raise[EV_IN_TOGGLE+i]    = rise_w[i] | fall_w[i];
         raise[EV_LT_RISE+i]      = rise_w[i+2];
         raise[EV_LT_FALL+i]      = fall_w[i+2];
         raise[EV_LT_TOGGLE+i]    = rise_w[i+2] | fall_w[i+2];
         // idle counting stops once halted; it wraps only when the timeout is all ones
         if (motion_w[i]) begin
            s_next.enc_idle[i] = '0;
            if (s_reg.enc_halt[i]) begin
               s_next.enc_halt[i]       = 1'b0;
               raise[EV_ENC_RESUME+i] = 1'b1;
            end
         end else if (!s_reg.enc_halt[i]) begin
            if (s_reg.enc_idle[i] > s_reg.tmo) begin
               s_next.enc_halt[i]     = 1'b1;
               raise[EV_ENC_HALT+i] = 1'b1;
            end else begin
               s_next.enc_idle[i] = s_reg.enc_idle[i] + 1'b1;
            end
         end
      end

      raise[EV_LATE]       = action_valid & (action_time < s_reg.ts);
      raise[EV_SPEED]      = link_speed != s_reg.spd_prev;
      raise[EV_SWITCH]     = switch_grant;
      raise[EV_ERROR]      = dev_error;
      raise[EV_TEST]       = s_reg.test_req;
      raise[EV_FRAME_TRIG] = frame_trig;
      raise[EV_EXPO_DONE]  = expo_done;

      // all fields of one capture come from the same cycle
      if (frame_trig) begin
         s_next.ft = '{ts: s_reg.ts, fid: frame_id};
      end
      if (expo_done) begin
         s_next.ed = '{ts: s_reg.ts, fid: frame_id};
      end

      // lowest pending code goes out first, one per cycle
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
         if (s_reg.pend[i]) begin
            pick = SEL_W'(i);
            hit  = 1'b1;
         end
      end
      if (hit) begin
         clr[pick] = 1'b1;
      end
      s_next.notify = hit;
      s_next.code   = pick;
      // a new occurrence beats the clear of the one being sent
      s_next.pend = (s_reg.pend & ~clr)
                  | (raise & (s_reg.en | TEST_MASK));

      // apb: answer in the second access cycle
      s_next.pready  = acc_w & ~s_reg.pready;
      s_next.pslverr = 1'b0;
      s_next.prdata  = '0;
      if (acc_w && !s_reg.pready) begin
         case (paddr)
            OFF_SELECT: begin
               s_next.prdata[SEL_W-1:0] = s_reg.sel;
            end
            OFF_ENABLE: begin
               if (s_reg.sel == SEL_W'(EV_TEST)) begin
                  s_next.prdata[0] = 1'b1;
               end else if (s_reg.sel < SEL_W'(NUM_EVT)) begin
                  s_next.prdata[0] = s_reg.en[s_reg.sel];
               end
            end
            OFF_TEST: begin
               s_next.prdata = '0;
            end
            OFF_ENC_TMO: begin
               s_next.prdata = s_reg.tmo;
            end
            OFF_PEND_LO: begin
               s_next.prdata = s_reg.pend[DATA_W-1:0];
            end
            OFF_PEND_HI: begin
               s_next.prdata[NUM_EVT-DATA_W-1:0] =
                  s_reg.pend[NUM_EVT-1:DATA_W];
            end
            OFF_FT_ID: begin
               s_next.prdata = ID_FRAME_TRIG;
            end
            OFF_FT_TIME: begin
               s_next.prdata = s_reg.ft.ts;
            end
            OFF_FT_FRM: begin
               s_next.prdata = s_reg.ft.fid;
            end
            OFF_ED_ID: begin
               s_next.prdata = ID_EXPO_DONE;
            end
            OFF_ED_TIME: begin
               s_next.prdata = s_reg.ed.ts;
            end
            OFF_ED_FRM: begin
               s_next.prdata = s_reg.ed.fid;
            end
            OFF_NOW: begin
               s_next.prdata = s_reg.ts;
            end
            default: begin
               s_next.pslverr = 1'b1;
            end
         endcase
      end

      if (commit_w && pwrite) begin
         case (paddr)
            OFF_SELECT: begin
               s_next.sel = pwdata[SEL_W-1:0];
            end
            OFF_ENABLE: begin
               if (s_reg.sel < SEL_W'(NUM_EVT)) begin
                  s_next.en[s_reg.sel] = pwdata[0];
               end
            end
            OFF_TEST: begin
               s_next.test_req = pwdata[0];
            end
            OFF_ENC_TMO: begin
               s_next.tmo = pwdata;
            end
            default: begin
               s_next.tmo = s_next.tmo;
            end
         endcase
      end
   end

   // =============================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= ST_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata       = s_reg.prdata;
   assign pready       = s_reg.pready;
   assign pslverr      = s_reg.pslverr;
   assign notify_valid = s_reg.notify;
   assign notify_code  = s_reg.code;

   // =============================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   test_always_on_a: assert property (
      s_reg.test_req |=> s_reg.pend[EV_TEST])
      else $error("test event not made pending");

   stream_begin_a: assert property (
      xfer_evt[0] && s_reg.en[EV_XFER_BASE] |=> s_reg.pend[EV_XFER_BASE])
      else $error("stream begin not made pending");

   line_rise_a: assert property (
      $rose(s_reg.pin_s2[0]) && s_reg.en[EV_IN_RISE]
      |=> s_reg.pend[EV_IN_RISE])
      else $error("line 0 rise missed");

   line_fall_a: assert property (
      $fell(s_reg.pin_s2[1]) && s_reg.en[EV_IN_FALL+1]
      |=> s_reg.pend[EV_IN_FALL+1])
      else $error("line 1 fall missed");

   link_toggle_a: assert property (
      $changed(s_reg.pin_s2[2]) && s_reg.en[EV_LT_TOGGLE]
      |=> s_reg.pend[EV_LT_TOGGLE])
      else $error("link trigger 0 toggle missed");

   counter_begin_a: assert property (
      $rose(cnt_run[0]) && s_reg.en[EV_CNT_BASE]
      |=> s_reg.pend[EV_CNT_BASE])
      else $error("counter 0 begin missed");

   error_off_a: assert property (
      dev_error && !s_reg.en[EV_ERROR] && !s_reg.pend[EV_ERROR]
      |=> !s_reg.pend[EV_ERROR])
      else $error("disabled error reported");

   enc_halt_a: assert property (
      $rose(s_reg.enc_halt[0])
      |-> $past(s_reg.enc_idle[0]) > $past(s_reg.tmo))
      else $error("encoder halted before timeout");

   capture_pair_a: assert property (
      frame_trig
      |=> s_reg.ft.ts == $past(s_reg.ts) && s_reg.ft.fid == $past(frame_id))
      else $error("frame trigger capture torn");

   type_id_a: assert property (
      s_reg.pready && !pwrite && paddr == OFF_FT_ID
      |-> s_reg.prdata == ID_FRAME_TRIG)
      else $error("frame trigger id wrong");

   timer_done_a: assert property (
      $fell(tmr_run[1]) && s_reg.en[EV_TMR_BASE+3]
      |=> s_reg.pend[EV_TMR_BASE+3])
      else $error("timer 1 done missed");

   enc_resume_a: assert property (
      $changed(s_reg.enc_s2[0]) && s_reg.enc_halt[0]
      && s_reg.en[EV_ENC_RESUME] |=> s_reg.pend[EV_ENC_RESUME])
      else $error("encoder 0 resume missed");

   late_action_a: assert property (
      action_valid && action_time < s_reg.ts && s_reg.en[EV_LATE]
      |=> s_reg.pend[EV_LATE])
      else $error("late action missed");

   speed_change_a: assert property (
      $changed(link_speed) && s_reg.en[EV_SPEED]
      |=> s_reg.pend[EV_SPEED])
      else $error("link speed change missed");

   switchover_a: assert property (
      switch_grant && s_reg.en[EV_SWITCH] |=> s_reg.pend[EV_SWITCH])
      else $error("switchover missed");

endmodule

`default_nettype wire

//--- testbench/host_event_sink.sv
// host-side sink: collects the reported event codes in arrival order
// assumes notify_valid is launched from pclk; each high cycle carries one code
`timescale 1ns/1ps
`default_nettype none
module host_event_sink
   import evt_notify_pkg::*;
(
   // clock
   input  wire logic             pclk,
   // notification from the device
   input  wire logic             notify_valid,
   input  wire logic [SEL_W-1:0] notify_code
);
   // ==========================================================
   // arrival log, drained by the bench
   logic [SEL_W-1:0] got_q[$];

   // only reported events reach the host, one code per cycle that notify_valid is high
   always @(posedge pclk) begin
      if (notify_valid === 1'b1)
         got_q.push_back(notify_code);
   end
endmodule
`default_nettype wire

//--- testbench/test_camera_event_notifier.sv
// self-checking bench for the camera event notifier
// assumes the package, the design and the host sink are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_camera_event_notifier
   import evt_notify_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic                   pclk         = 1'b0;
   logic                   presetn      = 1'b0;
   logic                   psel         = 1'b0;
   logic                   penable      = 1'b0;
   logic                   pwrite       = 1'b0;
   logic [ADDR_W-1:0]      paddr        = '0;
   logic [DATA_W-1:0]      pwdata       = '0;
   logic [DATA_W-1:0]      action_time  = '0;
   logic [DATA_W-1:0]      frame_id     = '0;
   logic [XFER_N-1:0]      xfer_evt     = '0;
   logic [1:0]             cnt_run      = '0;
   logic [1:0]             tmr_run      = '0;
   logic [1:0]             line_in      = '0;
   logic [1:0]             ltrig_in     = '0;
   logic [1:0]             enc_step     = '0;
   logic [SPD_W-1:0]       link_speed   = '0;
   logic                   action_valid = 1'b0;
   logic                   switch_grant = 1'b0;
   logic                   dev_error    = 1'b0;
   logic                   frame_trig   = 1'b0;
   logic                   expo_done    = 1'b0;
   logic [DATA_W-1:0]      prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   notify_valid;
   logic [SEL_W-1:0]       notify_code;
   logic [DATA_W-1:0]      rv;
   logic [DATA_W-1:0]      t0;
   logic [DATA_W-1:0]      t1;
   logic                   re;
   int                     error_cnt    = 0;
   int                     total_checks = 0;

   always #20 pclk = ~pclk;

   camera_event_notifier u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .xfer_evt(xfer_evt),
      .cnt_run(cnt_run), .tmr_run(tmr_run), .action_valid(action_valid),
      .action_time(action_time), .link_speed(link_speed),
      .switch_grant(switch_grant), .dev_error(dev_error),
      .frame_trig(frame_trig), .expo_done(expo_done), .frame_id(frame_id),
      .line_in(line_in), .ltrig_in(ltrig_in), .enc_step(enc_step),
      .notify_valid(notify_valid), .notify_code(notify_code));

   host_event_sink u_sink (
      .pclk(pclk), .notify_valid(notify_valid), .notify_code(notify_code));

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [DATA_W-1:0] got,
                      input logic [DATA_W-1:0] x);
      total_checks++;
      if (got !== x) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, x);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d, rv, re);
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
      apb(1'b0, a, '0, rv, re);
      chk(rv, x);
   endtask

   task automatic en(input int c, input logic v);
      wr(OFF_SELECT, DATA_W'(c));
      wr(OFF_ENABLE, {31'h0, v});
   endtask

   // bounded wait for the next reported code
   task automatic ev(input int c);
      int n;
      n = 0;
      while (u_sink.got_q.size() == 0 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (u_sink.got_q.size() > 0)
         chk(DATA_W'(u_sink.got_q.pop_front()), DATA_W'(c));
      else
         chk(32'hFFFF_FFFF, DATA_W'(c));
   endtask

   task automatic none();
      repeat (12) @(posedge pclk);
      chk(DATA_W'(u_sink.got_q.size()), 32'h0);
   endtask

   task automatic kick(input int w);
      case (w)
         0: dev_error <= 1'b1;
         1: switch_grant <= 1'b1;
         2: frame_trig <= 1'b1;
         3: expo_done <= 1'b1;
         default: action_valid <= 1'b1;
      endcase
      @(posedge pclk);
      {dev_error, switch_grant, frame_trig, expo_done, action_valid} <= '0;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      en(EV_TEST, 1'b0);
      rdc(OFF_ENABLE, 32'h1);
      wr(OFF_SELECT, DATA_W'(EV_ERROR));
      rdc(OFF_SELECT, DATA_W'(EV_ERROR));
      rdc(OFF_ENABLE, 32'h0);
      rdc(OFF_ENC_TMO, ENC_TMO_RST);
      wr(OFF_ENC_TMO, 32'h8);
      rdc(OFF_ENC_TMO, 32'h8);
      wr(OFF_FT_ID, 32'h0);
      rdc(OFF_FT_ID, ID_FRAME_TRIG);
      rdc(OFF_ED_ID, ID_EXPO_DONE);
      rdc(OFF_PEND_LO, 32'h0);
      rdc(OFF_PEND_HI, 32'h0);
      apb(1'b0, 8'hFC, '0, rv, re);
      chk({31'h0, re}, 32'h1);
      $display("test regs done");
   endtask

   task automatic t_enable();
      kick(0);
      none();
      en(EV_ERROR, 1'b1);
      wr(OFF_SELECT, DATA_W'(EV_SWITCH));
      rdc(OFF_ENABLE, 32'h0);
      kick(0);
      ev(EV_ERROR);
      $display("test enable done");
   endtask

   task automatic t_xfer();
      for (int i = 0; i < XFER_N; i++) en(i, 1'b1);
      for (int i = 0; i < XFER_N; i++) begin
         xfer_evt <= 11'h1 << i;
         @(posedge pclk);
         xfer_evt <= '0;
         ev(EV_XFER_BASE + i);
      end
      // simultaneous sources come out lowest code first
      xfer_evt <= 11'h401;
      @(posedge pclk);
      xfer_evt <= '0;
      ev(EV_XFER_BASE);
      ev(EV_XFER_BASE + 10);
      $display("test transfer done");
   endtask

   task automatic t_cnt();
      for (int i = EV_CNT_BASE; i < EV_ENC_HALT; i++) en(i, 1'b1);
      for (int i = 0; i < 2; i++) begin
         cnt_run[i] <= 1'b1;
         ev(EV_CNT_BASE + 2 * i);
         cnt_run[i] <= 1'b0;
         ev(EV_CNT_BASE + 2 * i + 1);
         tmr_run[i] <= 1'b1;
         ev(EV_TMR_BASE + 2 * i);
         tmr_run[i] <= 1'b0;
         ev(EV_TMR_BASE + 2 * i + 1);
      end
      $display("test counters done");
   endtask

   task automatic pin_edges(input logic lt, input int k);
      int b;
      b = lt ? EV_LT_RISE : EV_IN_RISE;
      if (lt) ltrig_in[k] <= 1'b1;
      else line_in[k] <= 1'b1;
      ev(b + k);
      ev(b + 4 + k);
      if (lt) ltrig_in[k] <= 1'b0;
      else line_in[k] <= 1'b0;
      ev(b + 2 + k);
      ev(b + 4 + k);
   endtask

   task automatic t_pins();
      for (int i = EV_IN_RISE; i < EV_LATE; i++) en(i, 1'b1);
      for (int k = 0; k < 2; k++) begin
         pin_edges(1'b0, k);
         pin_edges(1'b1, k);
      end
      $display("test pins done");
   endtask

   // both encoders halted silently while their events were off
   task automatic t_enc();
      for (int i = EV_ENC_HALT; i < EV_IN_RISE; i++) en(i, 1'b1);
      enc_step[0] <= ~enc_step[0];
      ev(EV_ENC_RESUME);
      ev(EV_ENC_HALT);
      none();
      $display("test encoder done");
   endtask

   task automatic t_misc();
      for (int i = EV_LATE; i < EV_ERROR; i++) en(i, 1'b1);
      kick(4);
      ev(EV_LATE);
      action_time <= 32'hFFFF_FFFF;
      kick(4);
      none();
      link_speed <= 3'h2;
      ev(EV_SPEED);
      kick(1);
      ev(EV_SWITCH);
      wr(OFF_TEST, 32'h1);
      ev(EV_TEST);
      $display("test misc done");
   endtask

   task automatic t_capture();
      logic [ADDR_W-1:0] a;
      for (int w = 2; w < 4; w++) begin
         a = (w == 2) ? OFF_FT_TIME : OFF_ED_TIME;
         frame_id <= 32'hA5A5_0000 + DATA_W'(w);
         apb(1'b0, OFF_NOW, '0, t0, re);
         kick(w);
         apb(1'b0, OFF_NOW, '0, t1, re);
         rdc(a + 8'h04, 32'hA5A5_0000 + DATA_W'(w));
         apb(1'b0, a, '0, rv, re);
         chk({31'h0, rv > t0 && rv < t1}, 32'h1);
      end
      $display("test capture done");
   endtask

   // ==========================================================
   // run control
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_enable();
      t_xfer();
      t_cnt();
      t_pins();
      t_enc();
      t_misc();
      t_capture();
      test_done();
   end
endmodule
`default_nettype wire
